// ### logic/rpcs_pkg.sv
// Constants shared by the register page context stack
package rpcs_pkg;

    // ========================================
    // Register offsets in the special-register space
    localparam logic [7:0] ADDR_CURRENT_PAGE = 8'h84;
    localparam logic [7:0] ADDR_SECOND_ENTRY = 8'h85;
    localparam logic [7:0] ADDR_BOTTOM_ENTRY = 8'h86;
    localparam logic [7:0] ADDR_PAGING_CTRL = 8'h96;

    // ========================================
    // Page on which the paging control register lives
    localparam logic [7:0] CTRL_REG_PAGE = 8'h0F;

    // ========================================
    // Field positions
    localparam int EN_BIT = 0;

    // ========================================
    // Reset values
    localparam logic [7:0] RST_CURRENT_PAGE = 8'h00;
    localparam logic [7:0] RST_SECOND_ENTRY = 8'h00;
    localparam logic [7:0] RST_BOTTOM_ENTRY = 8'h00;
    localparam logic [7:0] RST_PAGING_CTRL = 8'h01;

    // ========================================
    // Stack shape
    localparam int STACK_DEPTH = 3;
    localparam logic [7:0] EMPTY_PAGE = 8'h00;
    localparam logic [1:0] FILL_MAX = 2'h3;

    // Register select codes, one-hot except the all-zero none code
    typedef enum logic [3:0] {
        RPCS_SEL_NONE = 4'h0,
        RPCS_SEL_CUR = 4'h1,
        RPCS_SEL_NEXT = 4'h2,
        RPCS_SEL_LAST = 4'h4,
        RPCS_SEL_CTRL = 4'h8
    } rpcs_sel_t;

endpackage

// ### logic/rpcs_regsel.sv
// Address decoder of the page context stack registers
`timescale 1ns/1ps
`default_nettype none

module rpcs_regsel (
    input wire logic [7:0] addr,
    input wire logic [7:0] cur_page,
    output var rpcs_pkg::rpcs_sel_t sel
);

    // ========================================
    // Decode
    // Entries are seen from every page; control only from its own page
    always_comb
    begin
        if (addr == rpcs_pkg::ADDR_CURRENT_PAGE)
        begin
            sel = rpcs_pkg::RPCS_SEL_CUR;
        end
        else if (addr == rpcs_pkg::ADDR_SECOND_ENTRY)
        begin
            sel = rpcs_pkg::RPCS_SEL_NEXT;
        end
        else if (addr == rpcs_pkg::ADDR_BOTTOM_ENTRY)
        begin
            sel = rpcs_pkg::RPCS_SEL_LAST;
        end
        else if (addr == rpcs_pkg::ADDR_PAGING_CTRL &&
                 cur_page == rpcs_pkg::CTRL_REG_PAGE)
        begin
            sel = rpcs_pkg::RPCS_SEL_CTRL;
        end
        else
        begin
            sel = rpcs_pkg::RPCS_SEL_NONE;
        end
    end

endmodule

`default_nettype wire

// ### logic/rpcs_stack.sv
// Register page context stack: current page, second and bottom entries
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Return instruction copies the second entry into the current page.
// R2 - All three stack entries are readable and writable registers.
// R3 - Software edits of entries during a handler are honoured on return.
// R4 - Push happens only when an interrupt is vectored.
// R5 - Pop happens only when the return instruction executes.
// R6 - Enable cleared stops page switching and all push and pop.
// R7 - Enabled interrupt loads current page with the source's page.
// R8 - Disabled interrupt leaves the current page unchanged.
// R9 - Control at 0x96 page F, bit 0 enable, resets enabled.
// R10 - Current page at 0x84 on all pages, resets zero.
// R11 - Current page reads and writes never push or pop.
// R12 - Three byte stack: current, second, bottom.
// R13 - Writes to second or bottom entry never push or pop.
// R14 - Second entry at 0x85, resets zero, feeds current page on return.
// R15 - Bottom entry at 0x86, resets zero, feeds second entry on return.
// R16 - Unaltered stack returns to the page used before the interrupt.
// R17 - Push moves current to second, second to bottom, bottom lost.
// R18 - Pop moves bottom to second; bottom then holds 0x00.
// R19 - Core gives a page code with each interrupt and a return pulse.
module rpcs_stack #(
    parameter int PAGE_W = 8,
    parameter int DEPTH = rpcs_pkg::STACK_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    output logic SFR_RVALID,
    output logic SFR_SEL,
    input wire logic INT_TAKEN,
    input wire logic [7:0] INT_PAGE,
    input wire logic RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    output logic [7:0] CURRENT_PAGE,
    output logic AUTO_PAGING_EN,
    output logic [1:0] STACK_FILL,
    output logic STACK_OVERFLOW
);

    // ========================================
    // Elaboration checks
    generate
        if (PAGE_W != 8)
        begin : g_bad_width
            $error("rpcs_stack supports only 8-bit pages");
        end
        if (DEPTH != rpcs_pkg::STACK_DEPTH)
        begin : g_bad_depth
            $error("rpcs_stack supports only a three-entry stack");
        end
    endgenerate

    // ========================================
    // State
    logic [7:0] cur_page_ff;
    logic [7:0] next_entry_ff;
    logic [7:0] last_entry_ff;
    logic paging_en_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [1:0] fill_ff;
    logic overflow_ff;

    logic [7:0] nxt_cur_page;
    logic [7:0] nxt_next_entry;
    logic [7:0] nxt_last_entry;
    logic [7:0] nxt_rdata;

    rpcs_pkg::rpcs_sel_t sel;
    logic do_push;
    logic do_pop;
    logic wr_cur;
    logic wr_next;
    logic wr_last;
    logic wr_ctrl;

    // ========================================
    // Address decode, done against the page in use right now
    rpcs_regsel u_regsel (
        .addr(SFR_ADDR),
        .cur_page(cur_page_ff),
        .sel(sel)
    );

    // Write strobe for one selected register
    function automatic logic wr_hit(
        input rpcs_pkg::rpcs_sel_t s,
        input rpcs_pkg::rpcs_sel_t want,
        input logic wr
    );
        wr_hit = wr && (s == want);
    endfunction

    assign wr_cur = wr_hit(sel, rpcs_pkg::RPCS_SEL_CUR, SFR_WR);
    assign wr_next = wr_hit(sel, rpcs_pkg::RPCS_SEL_NEXT, SFR_WR);
    assign wr_last = wr_hit(sel, rpcs_pkg::RPCS_SEL_LAST, SFR_WR);
    assign wr_ctrl = wr_hit(sel, rpcs_pkg::RPCS_SEL_CTRL, SFR_WR);

    // ========================================
    // Stack events
    // Only the core's vector and return strobes move the stack; register
    // traffic never does, so a handler may rewrite entries freely.
    assign do_push = INT_TAKEN && paging_en_ff; // R4 R6 R19 R11 R13
    assign do_pop = RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC && paging_en_ff; // R5 R6 R19 R11 R13

    // ========================================
    // Next values of the three entries
    // A stack event wins over a register write in the same cycle: the core
    // vectors between instructions, so a clash means a lost edit, not a
    // corrupted stack.
    always_comb
    begin
        nxt_cur_page = cur_page_ff;
        nxt_next_entry = next_entry_ff;
        nxt_last_entry = last_entry_ff;
        if (do_push)
        begin
            nxt_cur_page = INT_PAGE; // R7
            nxt_next_entry = cur_page_ff; // R17 R12
            nxt_last_entry = next_entry_ff; // R17
        end
        else if (do_pop)
        begin
            nxt_cur_page = next_entry_ff; // R1 R14 R16 R3
            nxt_next_entry = last_entry_ff; // R15 R3
            nxt_last_entry = rpcs_pkg::EMPTY_PAGE; // R18
        end
        else
        begin
            if (wr_cur)
            begin
                nxt_cur_page = SFR_WDATA; // R10 R2
            end
            if (wr_next)
            begin
                nxt_next_entry = SFR_WDATA; // R14 R2
            end
            if (wr_last)
            begin
                nxt_last_entry = SFR_WDATA; // R15 R2
            end
        end
    end

    // ========================================
    // Current page
    // Disabled paging ignores interrupts, so the page stays put
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cur_page_ff <= rpcs_pkg::RST_CURRENT_PAGE; // R10
        end
        else
        begin
            cur_page_ff <= nxt_cur_page; // R8
        end
    end

    // ========================================
    // Second entry
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            next_entry_ff <= rpcs_pkg::RST_SECOND_ENTRY; // R14
        end
        else
        begin
            next_entry_ff <= nxt_next_entry;
        end
    end

    // ========================================
    // Bottom entry
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            last_entry_ff <= rpcs_pkg::RST_BOTTOM_ENTRY; // R15
        end
        else
        begin
            last_entry_ff <= nxt_last_entry;
        end
    end

    // ========================================
    // Paging control, bit 0 only; upper bits are not stored
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            paging_en_ff <= rpcs_pkg::RST_PAGING_CTRL[rpcs_pkg::EN_BIT]; // R9
        end
        else if (wr_ctrl)
        begin
            paging_en_ff <= SFR_WDATA[rpcs_pkg::EN_BIT]; // R9 R6
        end
    end

    // ========================================
    // Fill level and overflow
    // Counts pushed pages; a push with three held drops the bottom one,
    // which is flagged until a pop made with fewer than three held.
    // Software edits do not change the count.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            fill_ff <= 2'h0;
        end
        else if (do_push && fill_ff != rpcs_pkg::FILL_MAX)
        begin
            fill_ff <= fill_ff + 2'h1;
        end
        else if (do_pop && !do_push && fill_ff != 2'h0)
        begin
            fill_ff <= fill_ff - 2'h1;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            overflow_ff <= 1'b0;
        end
        else if (do_push && fill_ff == rpcs_pkg::FILL_MAX)
        begin
            overflow_ff <= 1'b1;
        end
        else if (do_pop && fill_ff != rpcs_pkg::FILL_MAX)
        begin
            overflow_ff <= 1'b0;
        end
    end

    // ========================================
    // Read path
    // Data is sampled before this cycle's update, so a read in the same
    // cycle as a push returns the old value.
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (sel == rpcs_pkg::RPCS_SEL_CUR)
        begin
            nxt_rdata = cur_page_ff; // R10 R2
        end
        else if (sel == rpcs_pkg::RPCS_SEL_NEXT)
        begin
            nxt_rdata = next_entry_ff; // R14 R2
        end
        else if (sel == rpcs_pkg::RPCS_SEL_LAST)
        begin
            nxt_rdata = last_entry_ff; // R15 R2
        end
        else if (sel == rpcs_pkg::RPCS_SEL_CTRL)
        begin
            nxt_rdata = {7'h00, paging_en_ff}; // R9
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdata_ff <= 8'h00;
        end
        else if (SFR_RD)
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= SFR_RD && (sel != rpcs_pkg::RPCS_SEL_NONE);
        end
    end

    // ========================================
    // Outputs
    assign SFR_RDATA = rdata_ff;
    assign SFR_RVALID = rvalid_ff;
    assign SFR_SEL = (sel != rpcs_pkg::RPCS_SEL_NONE);
    assign CURRENT_PAGE = cur_page_ff;
    assign AUTO_PAGING_EN = paging_en_ff;
    assign STACK_FILL = fill_ff;
    assign STACK_OVERFLOW = overflow_ff;

endmodule

`default_nettype wire

// ### test/rpcs_core_model.sv
// Core side model: interrupt vectoring and return strobes
`timescale 1ns/1ps
`default_nettype none
module rpcs_core_model (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic req_int,
    input wire logic req_ret,
    input wire logic [7:0] req_page,
    output logic INT_TAKEN,
    output logic RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    output logic [7:0] INT_PAGE
);
    // Page code is garbage outside a strobe so stale values never pass
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            INT_TAKEN <= 1'b0;
            RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC <= 1'b0;
            INT_PAGE <= 8'hA5;
        end
        else
        begin
            INT_TAKEN <= req_int;
            RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC <= req_ret;
            INT_PAGE <= req_int ? req_page : ~INT_PAGE;
        end
    end
endmodule
`default_nettype wire

// ### test/rpcs_stack_props.sv
// Port checker for the page context stack
`timescale 1ns/1ps
`default_nettype none
module rpcs_stack_props (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_RVALID,
    input wire logic SFR_SEL,
    input wire logic INT_TAKEN,
    input wire logic [7:0] INT_PAGE,
    input wire logic RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC,
    input wire logic [7:0] CURRENT_PAGE,
    input wire logic AUTO_PAGING_EN,
    input wire logic [1:0] STACK_FILL,
    input wire logic STACK_OVERFLOW
);
    // =====
    // Properties
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic evt;
    assign evt = (INT_TAKEN || RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC) && AUTO_PAGING_EN;
    push_load_a: assert property (INT_TAKEN && AUTO_PAGING_EN
        |=> CURRENT_PAGE == $past(INT_PAGE)) else $error("push page");
    page_hold_a: assert property (!evt && !(SFR_WR && SFR_ADDR == 8'h84)
        |=> $stable(CURRENT_PAGE)) else $error("page moved");
    page_write_a: assert property (SFR_WR && SFR_ADDR == 8'h84 && !evt
        |=> CURRENT_PAGE == $past(SFR_WDATA)) else $error("page write");
    fill_hold_a: assert property (!evt
        |=> $stable(STACK_FILL)) else $error("fill moved");
    push_fill_a: assert property (INT_TAKEN && AUTO_PAGING_EN
        && STACK_FILL != 2'h3 |=> STACK_FILL == $past(STACK_FILL) + 2'h1)
        else $error("push fill");
    pop_fill_a: assert property (RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC && !INT_TAKEN
        && AUTO_PAGING_EN && STACK_FILL != 2'h0
        |=> STACK_FILL == $past(STACK_FILL) - 2'h1) else $error("pop fill");
    ovf_set_a: assert property (INT_TAKEN && AUTO_PAGING_EN
        && STACK_FILL == 2'h3 |=> STACK_OVERFLOW) else $error("overflow");
    en_write_a: assert property (SFR_WR && SFR_SEL && SFR_ADDR == 8'h96
        |=> AUTO_PAGING_EN == $past(SFR_WDATA[0])) else $error("en write");
    page_read_a: assert property (SFR_RD && SFR_ADDR == 8'h84
        |=> SFR_RVALID && SFR_RDATA == $past(CURRENT_PAGE))
        else $error("page read");
    ctrl_page_a: assert property (SFR_ADDR == 8'h96
        |-> SFR_SEL == (CURRENT_PAGE == 8'h0F)) else $error("ctrl decode");
    miss_read_a: assert property (SFR_RD && !SFR_SEL
        |=> !SFR_RVALID && SFR_RDATA == 8'h00) else $error("miss read");
endmodule
bind rpcs_stack rpcs_stack_props chk (.*);
`default_nettype wire

// ### test/tb_rpcs_stack.sv
// Testbench of the page context stack
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("Error t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb_rpcs_stack;
    logic CLOCK = 0, RST_N = 0, SFR_WR = 0, SFR_RD = 0, ri = 0, rr = 0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, rp = 8'h00;
    logic [7:0] SFR_RDATA, CURRENT_PAGE, INT_PAGE;
    logic SFR_RVALID, SFR_SEL, INT_TAKEN, RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC;
    logic AUTO_PAGING_EN, STACK_OVERFLOW;
    logic [1:0] STACK_FILL;
    int n_errors = 0, checked = 0;
    rpcs_stack uut (.CLOCK(CLOCK), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
        .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
        .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .SFR_SEL(SFR_SEL),
        .INT_TAKEN(INT_TAKEN), .INT_PAGE(INT_PAGE), .RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC(RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC),
        .CURRENT_PAGE(CURRENT_PAGE), .AUTO_PAGING_EN(AUTO_PAGING_EN),
        .STACK_FILL(STACK_FILL), .STACK_OVERFLOW(STACK_OVERFLOW));
    rpcs_core_model m (.CLOCK(CLOCK), .RST_N(RST_N), .req_int(ri),
        .req_ret(rr), .req_page(rp), .INT_TAKEN(INT_TAKEN),
        .RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC(RETURN_FROM_INTERRUPT_INSTRUCTION_EXEC), .INT_PAGE(INT_PAGE));
    // =====
    // Access tasks
    task tick;
        @(posedge CLOCK);
        #2;
    endtask
    task wr(input logic [7:0] a, d);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1;
        tick;
        SFR_WR = 0;
        tick;
    endtask
    task rd(input logic [7:0] a, e, input logic v);
        SFR_ADDR = a;
        SFR_RD = 1;
        tick;
        SFR_RD = 0;
        `CHK({SFR_RVALID, SFR_RDATA}, {v, e})
        tick;
    endtask
    task ev(input logic i, r, input logic [7:0] p);
        ri = i;
        rr = r;
        rp = p;
        tick;
        ri = 0;
        rr = 0;
        tick;
    endtask
    task stk(input logic [7:0] c, n, l);
        rd(8'h84, c, 1);
        rd(8'h85, n, 1);
        rd(8'h86, l, 1);
        `CHK(CURRENT_PAGE, c)
    endtask
    task test_done;
        $display("checks=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // =====
    // Clock, watchdog, tests
    initial
    begin
        forever #12.5 CLOCK = ~CLOCK;
    end
    initial
    begin
        #100000;
        n_errors++;
        test_done;
    end
    initial
    begin
        repeat (8) @(posedge CLOCK);
        #2 RST_N = 1;
        stk(8'h00, 8'h00, 8'h00);
        `CHK(AUTO_PAGING_EN, 1'h1)
        rd(8'h96, 8'h00, 0);
        wr(8'h84, 8'h0F);
        rd(8'h96, 8'h01, 1);
        rd(8'h87, 8'h00, 0);
        $display("reset test done");
        ev(1, 0, 8'h02);
        stk(8'h02, 8'h0F, 8'h00);
        ev(1, 0, 8'h00);
        stk(8'h00, 8'h02, 8'h0F);
        `CHK(STACK_FILL, 2'h2)
        ev(0, 1, 8'h00);
        stk(8'h02, 8'h0F, 8'h00);
        ev(0, 1, 8'h00);
        stk(8'h0F, 8'h00, 8'h00);
        $display("nesting test done");
        wr(8'h86, 8'h55);
        stk(8'h0F, 8'h00, 8'h55);
        ev(1, 0, 8'h03);
        stk(8'h03, 8'h0F, 8'h00);
        wr(8'h85, 8'h01);
        wr(8'h86, 8'h03);
        ev(0, 1, 8'h00);
        stk(8'h01, 8'h03, 8'h00);
        ev(1, 1, 8'h09);
        stk(8'h09, 8'h01, 8'h03);
        wr(8'h84, 8'h0F);
        `CHK(STACK_FILL, 2'h1)
        $display("edit test done");
        wr(8'h96, 8'hFE);
        `CHK(AUTO_PAGING_EN, 1'h0)
        rd(8'h96, 8'h00, 1);
        ev(1, 0, 8'h07);
        stk(8'h0F, 8'h01, 8'h03);
        ev(0, 1, 8'h00);
        stk(8'h0F, 8'h01, 8'h03);
        wr(8'h96, 8'h01);
        rd(8'h96, 8'h01, 1);
        $display("enable test done");
        ev(1, 0, 8'h0A);
        ev(1, 0, 8'h0B);
        `CHK(STACK_OVERFLOW, 1'h0)
        ev(1, 0, 8'h0C);
        stk(8'h0C, 8'h0B, 8'h0A);
        `CHK({STACK_FILL, STACK_OVERFLOW}, 3'h7)
        ev(0, 1, 8'h00);
        stk(8'h0B, 8'h0A, 8'h00);
        `CHK(STACK_OVERFLOW, 1'h1)
        ev(0, 1, 8'h00);
        `CHK({STACK_FILL, STACK_OVERFLOW}, 3'h2)
        $display("overflow test done");
        test_done;
    end
endmodule
`default_nettype wire
